// [logic/autoneg_nextpage_consts.svh]
// Offsets, field positions and reset values for the next-page register group.
// Contract
// [R01] Base-page flag latches high, gated by alternate mode.
// [R02] Parallel-detection fault latches high until read.
// [R03] Expansion bit mirrors partner next-page ability.
// [R04] Local next-page ability reads one.
// [R05] New page loads partner word, sets flag.
// [R06] Page-received flag clears when software reads.
// [R07] Alternate mode also clears on page_rx false/tx disable.
// [R08] Partner auto-negotiation ability shown; upper bits zero.
// [R09] Transmit next-page bit writable, resets zero.
// [R10] Transmit reserved bit is read-only zero.
// [R11] Message-page resets one, code field resets one.
// [R12] Transmit second-acknowledge writable, resets zero.
// [R13] Transmit toggle alternates on successive pages.
// [R14] Received next-page bit read-only, resets zero.
// [R15] Received acknowledge bit reports partner receipt.
// [R16] Received message-page bit reports page type.
// [R17] Received second-acknowledge reports partner compliance.
// [R18] Received toggle and code field captured, read-only.
// [R19] Configuration bit enables alternate next-page mode.
// [R20] Read-only writes ignored; reads disturb only flags.
`ifndef AUTONEG_NEXTPAGE_CONSTS_SVH
`define AUTONEG_NEXTPAGE_CONSTS_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define IDX_EXPANSION       8'h06
`define IDX_TX_NEXT_PAGE    8'h07
`define IDX_RX_NEXT_PAGE    8'h08
`define IDX_CONFIG          8'h10

// ==========================================================================
// Expansion register fields.
`define EXP_BASE_PAGE       5
`define EXP_PD_FAULT        4
`define EXP_LP_NP_ABLE      3
`define EXP_NP_ABLE         2
`define EXP_PAGE_RX         1
`define EXP_LP_AN_ABLE      0

// ==========================================================================
// Configuration register fields.
`define CFG_TX_DISABLE      13
`define CFG_ALT_NP          1

// ==========================================================================
// Reset values.
`define TX_PAGE_RESET       16'h2001
`define LOCAL_NP_ABLE       1'b1

`endif

// [logic/autoneg_nextpage_pkg.sv]
// Types shared by the next-page register group and its neighbours.
package autoneg_nextpage_pkg;

  // One 16-bit next-page link code word.
  typedef struct packed {
    logic        np;
    logic        ack;
    logic        mp;
    logic        ack2;
    logic        toggle;
    logic [10:0] code;
  } page_word_t;

  // Levels reported by the arbitration state machine.
  typedef struct packed {
    logic mr_page_rx;
    logic base_page;
    logic lp_np_able;
    logic lp_an_able;
  } an_status_t;

endpackage : autoneg_nextpage_pkg

// [logic/autoneg_nextpage_regs.sv]
// APB register bank for the auto-negotiation expansion and next-page registers.
`timescale 1ns/10ps
`include "autoneg_nextpage_consts.svh"

module autoneg_nextpage_regs #(
  parameter int ADDR_W = 12
) (
  // Clock, reset and clock enable.
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              ce,
  // APB slave.
  input  wire logic [ADDR_W-1:0]                 paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // From the arbitration state machine.
  input  wire logic                              page_rx_event,
  input  wire logic                              page_is_next,
  input  wire autoneg_nextpage_pkg::page_word_t  rx_word,
  input  wire autoneg_nextpage_pkg::an_status_t  an_status,
  input  wire logic                              pd_fault_event,
  input  wire logic                              tx_page_sent,
  // To the arbitration state machine and the transmitter.
  output autoneg_nextpage_pkg::page_word_t       tx_page,
  output autoneg_nextpage_pkg::page_word_t       lp_base_word,
  output logic                                   alt_next_page_enable,
  output logic                                   transmit_disable
);

  // ==========================================================================
  // Elaboration check.
  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W must be at least 10 to reach every register");
  end

  // ==========================================================================
  // Address decode.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = ADDR_W'({idx, 2'b00});
  endfunction : reg_addr

  logic                            setup;
  logic                            done;
  logic                            wr;
  logic                            rd;
  logic                            hit_exp;
  logic                            hit_tx;
  logic                            hit_rx;
  logic                            hit_cfg;
  logic                            hit_any;
  logic                            loaded;
  logic                            capture;

  assign setup   = psel & ~penable;
  assign capture = ce & psel & ~loaded;
  assign done    = ce & psel & penable & loaded;
  assign wr      = done & pwrite;
  assign rd      = done & ~pwrite;
  assign hit_exp = (paddr == reg_addr(`IDX_EXPANSION));
  assign hit_tx  = (paddr == reg_addr(`IDX_TX_NEXT_PAGE));
  assign hit_rx  = (paddr == reg_addr(`IDX_RX_NEXT_PAGE));
  assign hit_cfg = (paddr == reg_addr(`IDX_CONFIG));
  assign hit_any = hit_exp | hit_tx | hit_rx | hit_cfg;

  // A frozen clock enable stretches the access phase rather than dropping it, and the
  // access cannot end before its read data has been captured.
  assign pready  = ce & loaded;
  assign pslverr = psel & penable & ~hit_any;

  // ==========================================================================
  // Transfer tracking.
  // Set by the enabled cycle that captures read data, cleared when the access ends.
  // A setup cycle lost to a frozen clock enable therefore costs one wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded <= 1'b0;
    end else if (ce) begin
      loaded <= psel & ~(penable & loaded);
    end
  end

  // ==========================================================================
  // Configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_next_page_enable <= 1'b0;
      transmit_disable     <= 1'b0;
    end else if (ce && wr && hit_cfg) begin
      alt_next_page_enable <= pwdata[`CFG_ALT_NP]; // [R19]
      transmit_disable     <= pwdata[`CFG_TX_DISABLE];
    end
  end

  // ==========================================================================
  // Local transmit next page.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_page <= `TX_PAGE_RESET; // [R09] [R11] [R12] [R13]
    end else if (ce) begin
      if (wr && hit_tx) begin
        tx_page     <= pwdata[15:0]; // [R09] [R12]
        tx_page.ack <= 1'b0; // [R10]
      end
      // Sending a page flips the toggle even if a write lands in the same cycle.
      if (tx_page_sent) begin
        tx_page.toggle <= ~tx_page.toggle; // [R13]
      end
    end
  end

  // ==========================================================================
  // Received pages.
  autoneg_nextpage_pkg::page_word_t lp_next;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_next      <= 16'h0000; // [R14]
      lp_base_word <= 16'h0000;
    end else if (ce && page_rx_event) begin
      if (page_is_next) begin
        lp_next <= rx_word; // [R05] [R14] [R15] [R16] [R17] [R18]
      end else begin
        lp_base_word <= rx_word; // [R05]
      end
    end
  end

  // ==========================================================================
  // Latching-high flags.
  // A read clears a flag only if the value just read showed it set, so an event
  // arriving between the capture of read data and the access edge survives.
  logic                            page_rx_flag;
  logic                            pd_fault_flag;
  logic                            base_page_flag;
  logic                            exp_read;
  logic                            alt_clear;

  assign exp_read  = rd & hit_exp;
  assign alt_clear = alt_next_page_enable & (~an_status.mr_page_rx | transmit_disable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_rx_flag <= 1'b0;
    end else if (ce) begin
      if (page_rx_event) begin
        page_rx_flag <= 1'b1; // [R05]
      end else if ((exp_read && prdata[`EXP_PAGE_RX]) || alt_clear) begin
        page_rx_flag <= 1'b0; // [R06] [R07]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_fault_flag <= 1'b0;
    end else if (ce) begin
      if (pd_fault_event) begin
        pd_fault_flag <= 1'b1; // [R02]
      end else if (exp_read && prdata[`EXP_PD_FAULT]) begin
        pd_fault_flag <= 1'b0; // [R02]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_page_flag <= 1'b0;
    end else if (ce) begin
      if (an_status.base_page) begin
        base_page_flag <= 1'b1; // [R01]
      end else if (exp_read && prdata[`EXP_BASE_PAGE]) begin
        base_page_flag <= 1'b0; // [R01]
      end
    end
  end

  // ==========================================================================
  // Read data.
  logic [15:0]                     exp_value;
  logic [15:0]                     cfg_value;

  always_comb begin
    exp_value                  = 16'h0000; // [R08]
    exp_value[`EXP_BASE_PAGE]  = alt_next_page_enable & base_page_flag; // [R01]
    exp_value[`EXP_PD_FAULT]   = pd_fault_flag; // [R02]
    exp_value[`EXP_LP_NP_ABLE] = an_status.lp_np_able; // [R03]
    exp_value[`EXP_NP_ABLE]    = `LOCAL_NP_ABLE; // [R04]
    exp_value[`EXP_PAGE_RX]    = page_rx_flag; // [R06]
    exp_value[`EXP_LP_AN_ABLE] = an_status.lp_an_able; // [R08]
  end

  always_comb begin
    cfg_value                  = 16'h0000;
    cfg_value[`CFG_ALT_NP]     = alt_next_page_enable;
    cfg_value[`CFG_TX_DISABLE] = transmit_disable;
  end

  // Read data is captured in the first enabled cycle of a transfer and held through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (capture) begin
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (1'b1)
          hit_exp: prdata[15:0] <= exp_value;
          hit_tx:  prdata[15:0] <= tx_page;
          hit_rx:  prdata[15:0] <= lp_next; // [R20]
          hit_cfg: prdata[15:0] <= cfg_value;
          default: prdata[15:0] <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PAGE_RX_SET: assert property ( // [R05]
    ce && page_rx_event |=> page_rx_flag)
    else $error("page-received flag not set by a new page");

  AST_PAGE_LOAD_NEXT: assert property ( // [R18]
    ce && page_rx_event && page_is_next |=> lp_next == $past(rx_word))
    else $error("received next page not loaded");

  AST_PAGE_RX_RDCLR: assert property ( // [R06]
    ce && exp_read && prdata[`EXP_PAGE_RX] && !page_rx_event |=> !page_rx_flag)
    else $error("page-received flag survived a read");

  AST_ALT_CLEAR: assert property ( // [R07]
    ce && alt_next_page_enable && transmit_disable && !page_rx_event
    |=> !page_rx_flag)
    else $error("alternate mode did not clear page-received flag");

  AST_PD_HOLD: assert property ( // [R02]
    pd_fault_flag && !(ce && exp_read) |=> pd_fault_flag)
    else $error("fault flag dropped without a read");

  AST_EXP_READ: assert property ( // [R04]
    ce && setup && !pwrite && hit_exp
    |=> prdata[`EXP_NP_ABLE] && prdata[31:6] == 26'h000_0000)
    else $error("expansion read shows wrong constant bits");

  AST_BASE_GATE: assert property ( // [R01]
    ce && setup && !pwrite && hit_exp && !alt_next_page_enable
    |=> !prdata[`EXP_BASE_PAGE])
    else $error("base-page flag visible with alternate mode off");

  AST_LP_NP_MIRROR: assert property ( // [R03]
    ce && setup && !pwrite && hit_exp
    |=> prdata[`EXP_LP_NP_ABLE] == $past(an_status.lp_np_able))
    else $error("partner next-page ability misreported");

  AST_TOGGLE: assert property ( // [R13]
    ce && tx_page_sent |=> tx_page.toggle != $past(tx_page.toggle))
    else $error("transmit toggle did not alternate");

  AST_TX_RSV: assert property ( // [R10]
    ce && wr && hit_tx ##1 1'b1 |-> !tx_page.ack [*2])
    else $error("transmit reserved bit not zero");

  AST_RO_WRITE: assert property ( // [R20]
    ce && wr && hit_rx && !page_rx_event |=> $stable(lp_next))
    else $error("write changed the received next page");

  AST_PD_SET: assert property ( // [R02]
    ce && pd_fault_event |=> pd_fault_flag)
    else $error("fault flag not set by a parallel-detection fault");

  AST_PD_RDCLR: assert property ( // [R02]
    ce && exp_read && prdata[`EXP_PD_FAULT] && !pd_fault_event |=> !pd_fault_flag)
    else $error("fault flag survived a read");

  AST_BASE_SET: assert property ( // [R01]
    ce && an_status.base_page |=> base_page_flag)
    else $error("base-page flag not latched");

  AST_BASE_RDCLR: assert property ( // [R01]
    ce && exp_read && prdata[`EXP_BASE_PAGE] && !an_status.base_page |=> !base_page_flag)
    else $error("base-page flag survived a read");

  AST_PAGE_RX_KEEP: assert property ( // [R06]
    ce && page_rx_flag && !alt_clear && !exp_read |=> page_rx_flag)
    else $error("page-received flag dropped without a clearing cause");

  AST_BASE_LOAD: assert property ( // [R05]
    ce && page_rx_event && !page_is_next |=> lp_base_word == $past(rx_word))
    else $error("received base page not loaded");

  AST_NEXT_KEEPS_BASE: assert property ( // [R05]
    ce && page_rx_event && page_is_next |=> $stable(lp_base_word))
    else $error("next page overwrote the base page");

  AST_LP_NEXT_HOLD: assert property ( // [R18]
    !(ce && page_rx_event && page_is_next) |=> $stable(lp_next))
    else $error("received next page changed without a new page");

  AST_LP_AN_MIRROR: assert property ( // [R08]
    capture && !pwrite && hit_exp
    |=> prdata[`EXP_LP_AN_ABLE] == $past(an_status.lp_an_able))
    else $error("partner auto-negotiation ability misreported");

  AST_TX_WRITE: assert property ( // [R09]
    ce && wr && hit_tx && !tx_page_sent
    |=> tx_page == {$past(pwdata[15]), 1'b0, $past(pwdata[13:0])})
    else $error("transmit next-page write did not land");

  AST_TOGGLE_HOLD: assert property ( // [R13]
    !(ce && (tx_page_sent || (wr && hit_tx))) |=> $stable(tx_page.toggle))
    else $error("transmit toggle changed without a sent page");

  AST_CFG_WRITE: assert property ( // [R19]
    wr && hit_cfg |=> alt_next_page_enable == $past(pwdata[`CFG_ALT_NP])
    && transmit_disable == $past(pwdata[`CFG_TX_DISABLE]))
    else $error("configuration write did not land");

  AST_UNMAPPED_READ: assert property ( // [R20]
    capture && !pwrite && !hit_any |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  // A frozen clock enable must hold prdata, tx_page, lp_next and page_rx_flag, including the read data
  // that an access stretched by the freeze will return later.
  AST_FROZEN: assert property (
    !ce |=> $stable(prdata) && $stable(tx_page) && $stable(lp_next) && $stable(page_rx_flag))
    else $error("state changed while the clock enable was low");

  // Main scenarios that the bench is expected to reach.
  COV_PAGE_READ: cover property (
    ce && page_rx_event ##[1:20] ce && exp_read && prdata[`EXP_PAGE_RX]);
  COV_PD_FAULT: cover property (ce && pd_fault_event ##1 pd_fault_flag);
  COV_TX_SENT: cover property (ce && wr && hit_tx ##[1:20] ce && tx_page_sent);
  COV_ALT_CLEAR: cover property (page_rx_flag && ce && alt_clear ##1 !page_rx_flag);
  COV_STRETCHED: cover property (psel && penable && !pready ##1 psel && penable && pready);

endmodule : autoneg_nextpage_regs

// [verification/link_partner_model.sv]
// Behavioural model of the arbitration side and link partner feeding the register group.
`timescale 1ns/10ps
module link_partner_model (
  // Clock.
  input  wire logic                        pclk,
  // Toward the register group.
  output logic                             page_rx_event,
  output logic                             page_is_next,
  output autoneg_nextpage_pkg::page_word_t rx_word,
  output autoneg_nextpage_pkg::an_status_t an_status,
  output logic                             pd_fault_event,
  output logic                             tx_page_sent
);
  // ==========================================================================
  // Link events.
  initial begin
    page_rx_event  = 1'b0;
    page_is_next   = 1'b0;
    rx_word        = 16'h0000;
    an_status      = 4'h0;
    pd_fault_event = 1'b0;
    tx_page_sent   = 1'b0;
  end

  task automatic send_page(input logic nxt, input logic [15:0] w);
    @(posedge pclk);
    page_rx_event <= 1'b1;
    page_is_next  <= nxt;
    rx_word       <= w;
    @(posedge pclk);
    page_rx_event <= 1'b0;
    // The word is stale once taken, so show its inverse rather than hold it.
    rx_word       <= ~w;
  endtask : send_page

  task automatic fault();
    @(posedge pclk);
    pd_fault_event <= 1'b1;
    @(posedge pclk);
    pd_fault_event <= 1'b0;
  endtask : fault

  task automatic sent();
    @(posedge pclk);
    tx_page_sent <= 1'b1;
    @(posedge pclk);
    tx_page_sent <= 1'b0;
  endtask : sent

  task automatic set_status(input logic [3:0] s);
    @(posedge pclk);
    an_status <= s;
  endtask : set_status
endmodule : link_partner_model

// [verification/autoneg_nextpage_regs_tb_top.sv]
// Self-checking testbench for the next-page register group.
`timescale 1ns/10ps
`include "autoneg_nextpage_consts.svh"
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, s); end end
module autoneg_nextpage_regs_tb_top;
  typedef struct packed {logic w; logic err; logic [31:0] d;} note_t;
  localparam logic [11:0] A_EXP = {2'b00, `IDX_EXPANSION, 2'b00};
  localparam logic [11:0] A_TX  = {2'b00, `IDX_TX_NEXT_PAGE, 2'b00};
  localparam logic [11:0] A_RX  = {2'b00, `IDX_RX_NEXT_PAGE, 2'b00};
  localparam logic [11:0] A_CFG = {2'b00, `IDX_CONFIG, 2'b00};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        page_rx_event;
  logic        page_is_next;
  logic        pd_fault_event;
  logic        tx_page_sent;
  logic        alt_next_page_enable;
  logic        transmit_disable;
  autoneg_nextpage_pkg::page_word_t rx_word;
  autoneg_nextpage_pkg::page_word_t tx_page;
  autoneg_nextpage_pkg::page_word_t lp_base_word;
  autoneg_nextpage_pkg::an_status_t an_status;
  note_t       notes[$];
  note_t       n;
  int          fails = 0;
  int          check_count = 0;
  int          seed = 32'h8168;
  logic [15:0] w;

  always #4 pclk = ~pclk;

  autoneg_nextpage_regs dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .page_rx_event(page_rx_event),
    .page_is_next(page_is_next), .rx_word(rx_word), .an_status(an_status),
    .pd_fault_event(pd_fault_event), .tx_page_sent(tx_page_sent), .tx_page(tx_page),
    .lp_base_word(lp_base_word), .alt_next_page_enable(alt_next_page_enable),
    .transmit_disable(transmit_disable));

  link_partner_model lp (.pclk(pclk), .page_rx_event(page_rx_event),
    .page_is_next(page_is_next), .rx_word(rx_word), .an_status(an_status),
    .pd_fault_event(pd_fault_event), .tx_page_sent(tx_page_sent));

  // ==========================================================================
  // Bus master and result monitor.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic err);
    notes.push_back({wr, err, e});
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      n = notes.pop_front();
      `CHK("pslverr", n.err, pslverr)
      if (!n.w) `CHK("prdata", n.d, prdata)
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // Generous against the few hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end

  // ==========================================================================
  // Scenarios.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_EXP, 32'h0, 32'h0000_0004, 1'b0);
    apb(1'b0, A_TX, 32'h0, 32'h0000_2001, 1'b0);
    apb(1'b0, A_RX, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, A_CFG, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, 12'h03C, 32'h0, 32'h0000_0000, 1'b1);
    apb(1'b1, A_EXP, 32'h0000_FFFF, 32'h0, 1'b0);
    apb(1'b0, A_EXP, 32'h0, 32'h0000_0004, 1'b0);
    lp.set_status(4'b0011);
    apb(1'b0, A_EXP, 32'h0, 32'h0000_000D, 1'b0);
    repeat (4) begin
      w = 16'($random(seed));
      lp.send_page(1'b1, w);
      apb(1'b0, A_EXP, 32'h0, 32'h0000_000F, 1'b0);
      apb(1'b0, A_RX, 32'h0, {16'h0000, w}, 1'b0);
      apb(1'b0, A_EXP, 32'h0, 32'h0000_000D, 1'b0);
    end
    apb(1'b1, A_RX, 32'h0000_FFFF, 32'h0, 1'b0);
    apb(1'b0, A_RX, 32'h0, {16'h0000, w}, 1'b0);
    w = 16'($random(seed));
    lp.send_page(1'b0, w);
    @(negedge pclk);
    `CHK("lp_base_word", w, lp_base_word)
    apb(1'b0, A_EXP, 32'h0, 32'h0000_000F, 1'b0);
    lp.fault();
    apb(1'b0, A_EXP, 32'h0, 32'h0000_001D, 1'b0);
    apb(1'b0, A_EXP, 32'h0, 32'h0000_000D, 1'b0);
    repeat (3) begin
      w = 16'($random(seed)) & 16'hBFFF;
      apb(1'b1, A_TX, {16'h0000, w}, 32'h0, 1'b0);
      apb(1'b0, A_TX, 32'h0, {16'h0000, w}, 1'b0);
    end
    apb(1'b1, A_TX, 32'h0000_BFFF, 32'h0, 1'b0);
    apb(1'b0, A_TX, 32'h0, 32'h0000_BFFF, 1'b0);
    lp.sent();
    apb(1'b0, A_TX, 32'h0, 32'h0000_B7FF, 1'b0);
    lp.sent();
    @(negedge pclk);
    `CHK("tx_page", 16'hBFFF, tx_page)
    // Freeze the block across the setup cycle; the read must still return fresh data.
    @(posedge pclk);
    ce <= 1'b0;
    fork
      apb(1'b0, A_TX, 32'h0, 32'h0000_BFFF, 1'b0);
      begin
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    lp.set_status(4'b0111);
    apb(1'b0, A_EXP, 32'h0, 32'h0000_000D, 1'b0);
    apb(1'b1, A_CFG, 32'h0000_0002, 32'h0, 1'b0);
    @(negedge pclk);
    `CHK("alt_next_page_enable", 1'b1, alt_next_page_enable)
    apb(1'b0, A_EXP, 32'h0, 32'h0000_002D, 1'b0);
    lp.send_page(1'b1, 16'h1234);
    apb(1'b0, A_EXP, 32'h0, 32'h0000_002D, 1'b0);
    lp.set_status(4'b1111);
    apb(1'b1, A_CFG, 32'h0000_2002, 32'h0, 1'b0);
    @(negedge pclk);
    `CHK("transmit_disable", 1'b1, transmit_disable)
    lp.send_page(1'b1, 16'h4321);
    apb(1'b0, A_EXP, 32'h0, 32'h0000_002D, 1'b0);
    apb(1'b1, A_CFG, 32'h0000_0002, 32'h0, 1'b0);
    lp.send_page(1'b1, 16'h0F0F);
    apb(1'b0, A_EXP, 32'h0, 32'h0000_002F, 1'b0);
    repeat (3) @(posedge pclk);
    close_out();
  end
endmodule : autoneg_nextpage_regs_tb_top
